// ---- bench/sces_card.sv ----
// smart-card model: answers a transmitted character with an error signal on request
`timescale 1ns/100ps
module sces_card
(
   input  wire logic mclk,
   input  wire logic tx_error_window,
   input  wire logic nack,
   output logic      line_out
);
   // the card pulls the line low through the guard time only when told to reject;
   // otherwise the pull-up holds it high; it answers on the rising edge because
   // the bench moves nack and the window on the falling one
   always_ff @(posedge mclk)
      line_out <= !(nack && tx_error_window);
endmodule : sces_card

// ---- bench/tb_top.sv ----
// self-checking bench for the smart-card error status flags
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   $display("ERROR %s expected %h seen %h", n, e, g); fails++; end end
module tb_top;
   import sces_pkg::*;
   logic mclk, resetn, te, re, rd, fw_full, win, line_in, nack, ov, es, full, stall;
   sces_mode_t mode;
   sces_rx_char_t rx;
   sces_flag_wr_t fw;
   logic [DATA_W-1:0] rdata;
   int fails, check_count, cycles;
   sces_error_flags dut (.mclk(mclk), .resetn(resetn), .protocol_mode(mode),
      .receive_enable_control(re), .transmit_enable_control(te), .rx_char(rx),
      .rx_data_read(rd), .rx_full_wr(fw_full), .rx_full_wdata(1'b0), .flag_wr(fw),
      .tx_error_window(win), .line_in(line_in), .overrun_error_flag(ov),
      .error_signal_status_flag(es), .receive_data_full_flag(full),
      .receive_data_register(rdata), .rx_stalled(stall));
   sces_card card (.mclk(mclk), .tx_error_window(win), .nack(nack), .line_out(line_in));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ---------------------------------------------------------------
   // shared stimulus
   // ---------------------------------------------------------------
   task automatic send(input logic [DATA_W-1:0] d, input logic bad = 1'b0);
      @(negedge mclk) rx = '{1'b1, bad, d};
      @(negedge mclk) rx.done = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : send
   task automatic flag_write(input logic o, input logic e);
      @(negedge mclk) fw = '{1'b1, o, e};
      @(negedge mclk) fw.wr = 1'b0;
      repeat (2) @(negedge mclk);
   endtask : flag_write
   task automatic card_reply(input logic reject);
      @(negedge mclk) nack = reject;
      win = 1'b1;
      repeat (6) @(negedge mclk);
      win = 1'b0;
      nack = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : card_reply
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_overrun;
      send(8'hA5);
      `CHK("full", 1'b1, full)
      send(8'h3C);
      `CHK("overrun", 1'b1, ov)
      `CHK("stalled", 1'b1, stall)
      `CHK("data kept", 8'hA5, rdata)
      @(negedge mclk) rd = 1'b1;
      @(negedge mclk) rd = 1'b0;
      send(8'h5A);
      `CHK("full blocked", 1'b0, full)
      `CHK("data blocked", 8'hA5, rdata)
      re = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("overrun re off", 1'b1, ov)
      re = 1'b1;
      flag_write(1'b1, 1'b0);
      `CHK("overrun w1", 1'b1, ov)
      flag_write(1'b0, 1'b1);
      `CHK("overrun w0", 1'b0, ov)
      send(8'hC3);
      `CHK("rx resumes", 8'hC3, rdata)
   endtask : test_overrun
   task automatic test_error_signal;
      card_reply(1'b0);
      `CHK("ers no reject", 1'b0, es)
      card_reply(1'b1);
      `CHK("ers set", 1'b1, es)
      te = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("ers te off", 1'b1, es)
      te = 1'b1;
      flag_write(1'b1, 1'b1);
      `CHK("ers w1", 1'b1, es)
      flag_write(1'b1, 1'b0);
      `CHK("ers w0", 1'b0, es)
      mode = SCES_MODE_T1;
      card_reply(1'b1);
      `CHK("ers t1", 1'b0, es)
   endtask : test_error_signal
   task automatic test_parity;
      @(negedge mclk) fw_full = 1'b1;
      @(negedge mclk) fw_full = 1'b0;
      `CHK("full w0", 1'b0, full)
      send(8'h96, 1'b1);
      `CHK("t1 parity load", 8'h96, rdata)
      `CHK("t1 parity full", 1'b1, full)
      @(negedge mclk) rd = 1'b1;
      @(negedge mclk) rd = 1'b0;
      mode = SCES_MODE_T0;
      send(8'h69, 1'b1);
      `CHK("t0 parity drop", 8'h96, rdata)
      `CHK("t0 parity full", 1'b0, full)
      `CHK("t0 parity ovr", 1'b0, ov)
   endtask : test_parity
   task automatic test_done;
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // cut a hang short well beyond the hundred or so cycles the scenarios need
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         test_done();
      end
   end
   initial
   begin
      resetn = 1'b0; mode = SCES_MODE_T0; re = 1'b1; te = 1'b1; rd = 1'b0;
      fw_full = 1'b0; win = 1'b0; nack = 1'b0; rx = '0; fw = '0;
      repeat (8) @(negedge mclk);
      `CHK("overrun reset", 1'b0, ov)
      `CHK("ers reset", 1'b0, es)
      resetn = 1'b1;
      repeat (2) @(negedge mclk);
      test_overrun();
      test_error_signal();
      test_parity();
      test_done();
   end
endmodule : tb_top

// ---- hw/sces_error_flags.sv ----
// overrun and error-signal status flags with the receive data register
`timescale 1ns/100ps

// How it works
// - overrun flag resets to 0; 1 means reception ended on overrun.
// - overrun sets when a reception completes while receive-data-full is 1, except a parity-bad one in T=0.
// - software writing 0 to the overrun flag clears it.
// - dropping receive enable leaves the overrun flag as it was.
// - on overrun the held character stays, the new one is dropped.
// - while overrun is 1 no further reception is accepted.
// - error-signal flag resets to 0, sets when card reports parity error.
// - transmitter sets error-signal flag on sampling the card's error signal.
// - in T=1 mode the error-signal flag is never set.
// - software writing 0 to the error-signal flag clears it.
// - dropping transmit enable leaves the error-signal flag as it was.
// - receive-data-full sets when a character passes normally to the register.
module sces_error_flags
(
   input  wire logic                      mclk,
   input  wire logic                      resetn,
   input  wire sces_pkg::sces_mode_t      protocol_mode,
   input  wire logic                      receive_enable_control,
   input  wire logic                      transmit_enable_control,
   input  wire sces_pkg::sces_rx_char_t   rx_char,
   input  wire logic                      rx_data_read,
   input  wire logic                      rx_full_wr,
   input  wire logic                      rx_full_wdata,
   input  wire sces_pkg::sces_flag_wr_t   flag_wr,
   input  wire logic                      tx_error_window,
   input  wire logic                      line_in,
   output logic                           overrun_error_flag,
   output logic                           error_signal_status_flag,
   output logic                           receive_data_full_flag,
   output logic [sces_pkg::DATA_W-1:0]    receive_data_register,
   output logic                           rx_stalled
);
   import sces_pkg::*;

   // ---------------------------------------------------------------
   // shared decode
   // ---------------------------------------------------------------
   // a write clears a flag only where its bit carries the clear value,
   // so software can clear one flag while writing 1 to the other
   function automatic logic write_clears
   (
      input logic wr,
      input logic wdata
   );
      write_clears = wr && (wdata == CLEAR_VALUE);
   endfunction : write_clears

   // an event that lands on the clearing write wins, otherwise a
   // character or error signal in that cycle would go unreported
   function automatic logic sticky_next
   (
      input logic cur,
      input logic set,
      input logic clr
   );
      sticky_next = set ? 1'b1 : (clr ? 1'b0 : cur);
   endfunction : sticky_next

   // ---------------------------------------------------------------
   // line sampling
   // ---------------------------------------------------------------
   logic line_sync;

   sces_sync u_line_sync
   (
      .mclk   (mclk),
      .resetn (resetn),
      .din    (line_in),
      .dout   (line_sync)
   );

   // ---------------------------------------------------------------
   // receive path decode
   // ---------------------------------------------------------------
   logic overrun_q;
   logic errsig_q;
   logic rx_accept;
   logic rx_normal;
   logic rx_load;
   logic overrun_set;
   logic full_clear;
   logic full_set;
   logic next_full;

   // completions are only seen while receive enable is on; the flags
   // themselves ignore receive enable, so dropping it keeps them
   assign rx_accept   = rx_char.done && receive_enable_control && !overrun_q;
   // in T=0 a parity-bad character never reaches the register
   assign rx_normal   = rx_accept
                        && !(rx_char.parity_bad && (protocol_mode == SCES_MODE_T0));
   assign overrun_set = rx_normal && receive_data_full_flag;
   assign rx_load     = rx_normal && !receive_data_full_flag;
   assign full_set    = rx_load;
   assign full_clear  = rx_data_read || write_clears(rx_full_wr, rx_full_wdata);
   assign next_full   = sticky_next(receive_data_full_flag, full_set, full_clear);

   // ---------------------------------------------------------------
   // overrun flag decode
   // ---------------------------------------------------------------
   logic overrun_clear;
   logic next_overrun;

   // the port copy takes the same next value as the internal flag, so the
   // reported flag and the receive stall always move on one edge; software
   // never sees the flag clear while the receiver is still held
   assign overrun_clear = write_clears(flag_wr.wr, flag_wr.overrun_wdata);
   assign next_overrun  = sticky_next(overrun_q, overrun_set, overrun_clear);

   // ---------------------------------------------------------------
   // transmit error signal decode
   // ---------------------------------------------------------------
   logic errsig_set;

   // a low level in the guard window is the card's error signal;
   // transmit enable is not consulted so clearing it keeps the flag
   assign errsig_set = tx_error_window && !line_sync
                       && (protocol_mode == SCES_MODE_T0);

   logic errsig_clear;
   logic next_errsig;

   // transmit enable is not an input to either term, which keeps the flag
   // through a transmitter shutdown
   assign errsig_clear = write_clears(flag_wr.wr, flag_wr.error_signal_wdata);
   assign next_errsig  = sticky_next(errsig_q, errsig_set, errsig_clear);

   // ---------------------------------------------------------------
   // sticky flags
   // ---------------------------------------------------------------
   sces_flag u_overrun
   (
      .mclk   (mclk),
      .resetn (resetn),
      .set    (overrun_set),
      .wr     (flag_wr.wr),
      .wdata  (flag_wr.overrun_wdata),
      .flag   (overrun_q)
   );

   sces_flag u_errsig
   (
      .mclk   (mclk),
      .resetn (resetn),
      .set    (errsig_set),
      .wr     (flag_wr.wr),
      .wdata  (flag_wr.error_signal_wdata),
      .flag   (errsig_q)
   );

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   // a read or a write of 0 in the cycle of a new load leaves the flag set
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         receive_data_full_flag <= FLAG_RESET;
      else
         receive_data_full_flag <= next_full;
   end

   // only a normal load replaces the held character; overrun and refused
   // completions never touch it
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         receive_data_register <= '0;
      else if (rx_load)
         receive_data_register <= rx_char.data;
   end

   // the internal flag gates reception, this copy only reports it
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         overrun_error_flag <= FLAG_RESET;
      else
         overrun_error_flag <= next_overrun;
   end

   // transmit enable never reaches this register
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         error_signal_status_flag <= FLAG_RESET;
      else
         error_signal_status_flag <= next_errsig;
   end

   // the stall follows the overrun flag exactly; reception resumes on the
   // edge that clears the flag
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rx_stalled <= FLAG_RESET;
      else
         rx_stalled <= next_overrun;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   overrun_sets_a: assert property (@(posedge mclk) disable iff (!resetn)
      overrun_set |=> overrun_error_flag)
      else $error("overrun flag did not set");

   overrun_data_a: assert property (@(posedge mclk) disable iff (!resetn)
      overrun_set |=> $stable(receive_data_register))
      else $error("held character overwritten on overrun");

   overrun_stall_a: assert property (@(posedge mclk) disable iff (!resetn)
      overrun_q |-> !rx_load)
      else $error("character loaded while overrun pending");

   overrun_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
      (flag_wr.wr && !flag_wr.overrun_wdata && !overrun_set) |=> !overrun_error_flag)
      else $error("overrun flag not cleared by write of 0");

   overrun_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      (overrun_error_flag && !(flag_wr.wr && !flag_wr.overrun_wdata)) |=> overrun_error_flag)
      else $error("overrun flag dropped without a write of 0");

   errsig_t1_a: assert property (@(posedge mclk) disable iff (!resetn)
      (protocol_mode == SCES_MODE_T1 && !error_signal_status_flag) |=> !errsig_q)
      else $error("error signal flag set in T=1 mode");

   errsig_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
      (flag_wr.wr && !flag_wr.error_signal_wdata && !errsig_set)
      |=> !error_signal_status_flag)
      else $error("error signal flag not cleared by write of 0");

   full_sets_a: assert property (@(posedge mclk) disable iff (!resetn)
      rx_load |=> (receive_data_full_flag && receive_data_register == $past(rx_char.data)))
      else $error("normal character did not fill the register");

   // ---------------------------------------------------------------
   // further receive checks
   // ---------------------------------------------------------------
   overrun_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(overrun_error_flag) |-> $past(overrun_set))
      else $error("overrun flag rose without an overrun");

   data_change_a: assert property (@(posedge mclk) disable iff (!resetn)
      $changed(receive_data_register) |-> $past(rx_load))
      else $error("receive data changed without a normal load");

   rx_refused_a: assert property (@(posedge mclk) disable iff (!resetn)
      (rx_char.done && overrun_error_flag) |=> $stable(receive_data_register))
      else $error("completion accepted while overrun flag set");

   stall_release_a: assert property (@(posedge mclk) disable iff (!resetn)
      (overrun_error_flag && overrun_clear && !overrun_set) |=> !rx_stalled)
      else $error("receiver still stalled after overrun clear");

   rx_off_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      (!receive_enable_control && !overrun_clear)
      |=> (overrun_error_flag == $past(overrun_error_flag)))
      else $error("overrun flag moved while receive enable off");

   full_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(receive_data_full_flag) |-> $past(rx_load))
      else $error("full flag rose without a normal load");

   parity_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
      (rx_accept && rx_char.parity_bad && protocol_mode == SCES_MODE_T0)
      |=> $stable(receive_data_register))
      else $error("parity-bad character loaded in T=0 mode");

   t1_parity_load_a: assert property (@(posedge mclk) disable iff (!resetn)
      (rx_accept && protocol_mode == SCES_MODE_T1 && !receive_data_full_flag)
      |=> (receive_data_full_flag && receive_data_register == $past(rx_char.data)))
      else $error("character not loaded in T=1 mode");

   // ---------------------------------------------------------------
   // further transmit checks
   // ---------------------------------------------------------------
   errsig_sets_a: assert property (@(posedge mclk) disable iff (!resetn)
      errsig_set |=> error_signal_status_flag)
      else $error("error signal flag did not set");

   errsig_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(error_signal_status_flag) |-> $past(errsig_set))
      else $error("error signal flag rose without an error signal");

   errsig_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(error_signal_status_flag) |-> ($past(protocol_mode) == SCES_MODE_T0))
      else $error("error signal flag rose outside T=0 mode");

   errsig_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      (error_signal_status_flag && !errsig_clear) |=> error_signal_status_flag)
      else $error("error signal flag dropped without a write of 0");

   tx_off_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      (!transmit_enable_control && error_signal_status_flag && !errsig_clear)
      |=> error_signal_status_flag)
      else $error("error signal flag lost while transmit enable off");

endmodule : sces_error_flags

// ---- hw/sces_flag.sv ----
// one sticky status flag: hardware set, software write-0 clear
`timescale 1ns/100ps
module sces_flag
(
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic set,
   input  wire logic wr,
   input  wire logic wdata,
   output logic      flag
);
   import sces_pkg::*;

   logic clear;
   logic next_flag;

   // writing 1 does nothing; the set beats a simultaneous clear
   assign clear     = wr && (wdata == CLEAR_VALUE);
   assign next_flag = set ? 1'b1 : (clear ? 1'b0 : flag);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         flag <= FLAG_RESET;
      else
         flag <= next_flag;
   end

endmodule : sces_flag

// ---- hw/sces_pkg.sv ----
// shared types and constants for the smart-card error status flags block
package sces_pkg;

   localparam int unsigned DATA_W      = 8;
   localparam logic        FLAG_RESET  = 1'b0;
   localparam logic        CLEAR_VALUE = 1'b0;
   // idle level of the serial line, also the synchroniser's reset value
   localparam logic        LINE_IDLE   = 1'b1;

   // ---------------------------------------------------------------
   // protocol modes
   // ---------------------------------------------------------------
   typedef enum logic
   {
      SCES_MODE_T0,
      SCES_MODE_T1
   } sces_mode_t;

   // software write to the status flags: strobe plus the written bits
   typedef struct packed
   {
      logic wr;
      logic overrun_wdata;
      logic error_signal_wdata;
   } sces_flag_wr_t;

   // a character completed by the receive shift register
   typedef struct packed
   {
      logic              done;
      logic              parity_bad;
      logic [DATA_W-1:0] data;
   } sces_rx_char_t;

endpackage : sces_pkg

// ---- hw/sces_sync.sv ----
// two-flop synchroniser for one line-side level
`timescale 1ns/100ps
module sces_sync
(
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);
   import sces_pkg::*;

   logic stage1;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1 <= LINE_IDLE;
         dout   <= LINE_IDLE;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : sces_sync
